// >>> pkg/bfs_pkg.sv
// Shared constants and types of the ballast fault sequencer.
package bfs_pkg;

	localparam int unsigned ADDR_W = 4;

	localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hC;

	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam logic        CTRL_EN_RESET = 1'b1;

	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned IRQ_FAULT     = 0;
	localparam int unsigned IRQ_SHUTDOWN  = 1;
	localparam int unsigned IRQ_BUS_DROP  = 2;
	localparam int unsigned IRQ_RUN_ENTRY = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	localparam int unsigned ST_MODE_LSB  = 0;
	localparam int unsigned ST_FAULT_BIT = 8;
	localparam int unsigned ST_CAUSE_LSB = 9;
	localparam int unsigned ST_IN_LSB    = 16;

	localparam int unsigned CAUSE_W     = 2;
	localparam int unsigned CAUSE_UPPER = 0;
	localparam int unsigned CAUSE_LOWER = 1;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'b0;

	localparam int unsigned SYNC_W = 9;

	typedef enum logic [5:0] {
		M_IDLE     = 6'h01,
		M_PREHEAT  = 6'h02,
		M_IGNITION = 6'h04,
		M_RUN      = 6'h08,
		M_FAULT    = 6'h10,
		M_SHUTDOWN = 6'h20
	} bfs_mode_t;

endpackage : bfs_pkg

// >>> verilog/bfs_sync.sv
// Two-stage synchroniser for a group of asynchronous comparator levels.
`timescale 1ns/100ps
`default_nettype none
module bfs_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} bfs_sync_state_t;

	bfs_sync_state_t st;
	bfs_sync_state_t next_st;

	always_comb begin
		next_st.meta   = async_in;
		next_st.stable = st.meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stable;

endmodule : bfs_sync
`default_nettype wire

// >>> verilog/bfs_sequencer.sv
// Protection and restart sequencer of a half-bridge ballast controller with AHB-Lite registers.
// Function
// - Start oscillating only with supply ok, bus sense ok and shutdown input low.
// - A low bus-sense indication during operation stops the oscillator.
// - On bus recovery restart from the first mode of the sequence.
// - Shutdown input high disables oscillator, gate drives low, micropower mode.
// - Shutdown input returning low restarts from the beginning of the sequence.
// - Any current-sense fault sets fault latch, stops oscillator, enters micropower; a same-cycle bus drop or software stop sets the latch but goes to idle.
// - Current sense is evaluated every switching cycle, fault caught within it.
// - Upper current threshold active only from end of preheat onward.
// - Lower current threshold active only from start of run mode onward.
// - Lower threshold sampled at each falling edge of the low-side drive.
// - Shutdown input high clears fault latch and holds an unlatched off state.
// - After unlatched shutdown, startup begins again when shutdown input falls.
// - Supply undervoltage lockout also clears the fault latch.
// - Preheat cap at lower threshold ends preheat and releases resistor node.
// - Preheat cap at upper threshold enters run and turns on run switch.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bfs_sequencer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        supply_ok,
	input  wire logic        bus_voltage_sense,
	input  wire logic        lamp_sense_shutdown,
	input  wire logic        cs_upper_crossed,
	input  wire logic        cs_lower_crossed,
	input  wire logic        preheat_cap_low_thr,
	input  wire logic        preheat_cap_high_thr,
	input  wire logic        osc_low_cmd,
	input  wire logic        osc_high_cmd,
	output logic             osc_enable,
	output logic             low_side_drive,
	output logic             high_side_drive,
	output logic             micropower,
	output logic             fault_latch,
	output logic             preheat_resistor_node_out,
	output logic             preheat_resistor_node_oe_n,
	output logic             run_switch_out,
	output logic             run_switch_oe_n,
	output logic             irq
);

	typedef struct packed {
		bfs_pkg::bfs_mode_t               mode;
		logic                             fault;
		logic [bfs_pkg::CAUSE_W-1:0]      cause;
		logic                             ctrl_en;
		logic [bfs_pkg::IRQ_W-1:0]        irq_stat;
		logic [bfs_pkg::IRQ_W-1:0]        irq_mask;
		logic                             wr_pend;
		logic [bfs_pkg::ADDR_W-1:0]       wr_addr;
		logic [31:0]                      rdata;
		logic                             lo;
		logic                             ho;
	} bfs_seq_state_t;

	bfs_seq_state_t st;
	bfs_seq_state_t next_st;

	logic [bfs_pkg::SYNC_W-1:0] sync_q;
	logic sup_s;
	logic bus_s;
	logic sd_s;
	logic csu_s;
	logic csl_s;
	logic capl_s;
	logic caph_s;
	logic lo_s;
	logic ho_s;
	logic running;
	logic lo_fall;
	logic addr_ok;

	// Comparators carry their hysteresis outside; only clean levels come in here.
	bfs_sync #(
		.WIDTH    (bfs_pkg::SYNC_W)
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({osc_high_cmd, osc_low_cmd, preheat_cap_high_thr, preheat_cap_low_thr,
			cs_lower_crossed, cs_upper_crossed, lamp_sense_shutdown, bus_voltage_sense,
			supply_ok}),
		.sync_out (sync_q)
	);

	assign {ho_s, lo_s, caph_s, capl_s, csl_s, csu_s, sd_s, bus_s, sup_s} = sync_q;

	assign running = (st.mode == bfs_pkg::M_PREHEAT) || (st.mode == bfs_pkg::M_IGNITION)
		|| (st.mode == bfs_pkg::M_RUN);
	// Falling edge of our own low-side drive, seen one cycle before it lands.
	assign lo_fall = st.lo && !lo_s;
	assign addr_ok = hsel && hready && (htrans == bfs_pkg::HTRANS_NONSEQ
		|| htrans == bfs_pkg::HTRANS_SEQ);

	always_comb begin
		logic [bfs_pkg::IRQ_W-1:0] ev;
		logic [31:0]               rd;
		logic                      nrun;
		ev      = '0;
		rd      = '0;
		nrun    = 1'b0;
		next_st = st;

		unique case (st.mode)
			bfs_pkg::M_IDLE: begin
				if (sup_s && bus_s && !sd_s && st.ctrl_en) begin
					next_st.mode = bfs_pkg::M_PREHEAT;
				end
			end
			bfs_pkg::M_PREHEAT: begin
				if (capl_s) begin
					next_st.mode = bfs_pkg::M_IGNITION;
				end
			end
			bfs_pkg::M_IGNITION: begin
				if (csu_s) begin
					next_st.mode  = bfs_pkg::M_FAULT;
					next_st.fault = 1'b1;
					next_st.cause[bfs_pkg::CAUSE_UPPER] = 1'b1;
					ev[bfs_pkg::IRQ_FAULT] = 1'b1;
				end else if (caph_s) begin
					next_st.mode = bfs_pkg::M_RUN;
					ev[bfs_pkg::IRQ_RUN_ENTRY] = 1'b1;
				end
			end
			bfs_pkg::M_RUN: begin
				// Both thresholds are looked at on every cycle of the bridge.
				if (csu_s || (lo_fall && !csl_s)) begin
					next_st.mode  = bfs_pkg::M_FAULT;
					next_st.fault = 1'b1;
					next_st.cause[bfs_pkg::CAUSE_UPPER] = csu_s;
					next_st.cause[bfs_pkg::CAUSE_LOWER] = lo_fall && !csl_s;
					ev[bfs_pkg::IRQ_FAULT] = 1'b1;
				end
			end
			bfs_pkg::M_FAULT: begin
				next_st.mode = bfs_pkg::M_FAULT;
			end
			bfs_pkg::M_SHUTDOWN: begin
				if (!sd_s) begin
					next_st.mode = bfs_pkg::M_IDLE;
				end
			end
			default: begin
				next_st.mode = bfs_pkg::M_IDLE;
			end
		endcase

		// A bus drop or a software stop while running lands in idle unless shutdown is high, so recovery replays preheat.
		if (running && (!bus_s || !st.ctrl_en)) begin
			next_st.mode = bfs_pkg::M_IDLE;
			next_st.cause = '0;
			ev = '0;
			ev[bfs_pkg::IRQ_BUS_DROP] = !bus_s;
		end
		if (sd_s) begin
			next_st.mode  = bfs_pkg::M_SHUTDOWN;
			next_st.fault = 1'b0;
			next_st.cause = '0;
			ev = '0;
			ev[bfs_pkg::IRQ_SHUTDOWN] = (st.mode != bfs_pkg::M_SHUTDOWN);
		end
		if (!sup_s) begin
			next_st.mode  = bfs_pkg::M_IDLE;
			next_st.fault = 1'b0;
			next_st.cause = '0;
			ev = '0;
		end

		nrun = (next_st.mode == bfs_pkg::M_PREHEAT) || (next_st.mode == bfs_pkg::M_IGNITION)
			|| (next_st.mode == bfs_pkg::M_RUN);
		next_st.lo = nrun && lo_s;
		next_st.ho = nrun && ho_s && !lo_s;

		// Write data phase; a hardware event in the same cycle beats the clear.
		next_st.wr_pend = addr_ok && hwrite;
		next_st.wr_addr = haddr[bfs_pkg::ADDR_W-1:0];
		if (st.wr_pend) begin
			unique case (st.wr_addr)
				bfs_pkg::OFS_CTRL: next_st.ctrl_en = hwdata[bfs_pkg::CTRL_EN_BIT];
				bfs_pkg::OFS_IRQ_STAT: next_st.irq_stat = st.irq_stat
					& ~hwdata[bfs_pkg::IRQ_W-1:0];
				bfs_pkg::OFS_IRQ_MASK: next_st.irq_mask = hwdata[bfs_pkg::IRQ_W-1:0];
				default: next_st.ctrl_en = st.ctrl_en;
			endcase
		end
		next_st.irq_stat = next_st.irq_stat | ev;

		// Read data is prepared in the address phase so the slave never waits.
		unique case (haddr[bfs_pkg::ADDR_W-1:0])
			bfs_pkg::OFS_CTRL: rd[bfs_pkg::CTRL_EN_BIT] = st.ctrl_en;
			bfs_pkg::OFS_STATUS: begin
				rd[bfs_pkg::ST_MODE_LSB +: $bits(bfs_pkg::bfs_mode_t)] = st.mode;
				rd[bfs_pkg::ST_FAULT_BIT] = st.fault;
				rd[bfs_pkg::ST_CAUSE_LSB +: bfs_pkg::CAUSE_W] = st.cause;
				rd[bfs_pkg::ST_IN_LSB +: bfs_pkg::SYNC_W] = sync_q;
			end
			bfs_pkg::OFS_IRQ_STAT: rd[bfs_pkg::IRQ_W-1:0] = st.irq_stat;
			bfs_pkg::OFS_IRQ_MASK: rd[bfs_pkg::IRQ_W-1:0] = st.irq_mask;
			default: rd = '0;
		endcase
		next_st.rdata = (addr_ok && !hwrite) ? rd : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st          <= '0;
			st.mode     <= bfs_pkg::M_IDLE;
			st.ctrl_en  <= bfs_pkg::CTRL_EN_RESET;
			st.irq_mask <= bfs_pkg::IRQ_MASK_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata                     = st.rdata;
	assign hreadyout                  = 1'b1;
	assign hresp                      = bfs_pkg::HRESP_OKAY;
	assign osc_enable                 = running;
	assign low_side_drive             = st.lo;
	assign high_side_drive            = st.ho;
	// Micropower covers the latched fault and the unlatched lamp-removal state.
	assign micropower                 = (st.mode == bfs_pkg::M_FAULT)
		|| (st.mode == bfs_pkg::M_SHUTDOWN);
	assign fault_latch                = st.fault;
	assign preheat_resistor_node_out  = 1'b0;
	assign preheat_resistor_node_oe_n = !(st.mode == bfs_pkg::M_PREHEAT
		|| st.mode == bfs_pkg::M_IDLE);
	assign run_switch_out             = 1'b0;
	assign run_switch_oe_n            = !(st.mode == bfs_pkg::M_RUN);
	assign irq                        = |(st.irq_stat & st.irq_mask);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic ok_in;
	assign ok_in = sup_s && bus_s && !sd_s && st.ctrl_en;

	property p_start_cond;
		$rose(st.mode == bfs_pkg::M_PREHEAT) |-> $past(sup_s && bus_s && !sd_s);
	endproperty
	a_start_cond: assert property (p_start_cond)
		else $error("Started without conditions.");

	property p_bus_stop;
		running && !bus_s && sup_s && !sd_s |=> st.mode == bfs_pkg::M_IDLE && !osc_enable;
	endproperty
	a_bus_stop: assert property (p_bus_stop) else $error("Bus drop did not stop.");

	property p_restart_first;
		$rose(running) |-> st.mode == bfs_pkg::M_PREHEAT;
	endproperty
	a_restart_first: assert property (p_restart_first)
		else $error("Restart skipped preheat.");

	property p_sd_off;
		sd_s && sup_s |=> micropower && !low_side_drive && !high_side_drive && !osc_enable;
	endproperty
	a_sd_off: assert property (p_sd_off) else $error("Shutdown input not obeyed.");

	property p_upper_fault;
		(st.mode == bfs_pkg::M_IGNITION || st.mode == bfs_pkg::M_RUN) && csu_s && ok_in
			|=> fault_latch && micropower ##1 !low_side_drive;
	endproperty
	a_upper_fault: assert property (p_upper_fault) else $error("Upper fault missed.");

	property p_no_fault_preheat;
		st.mode == bfs_pkg::M_PREHEAT |=> st.mode != bfs_pkg::M_FAULT;
	endproperty
	a_no_fault_preheat: assert property (p_no_fault_preheat)
		else $error("Fault in preheat.");

	property p_lower_sample;
		st.mode == bfs_pkg::M_RUN && lo_fall && !csl_s && ok_in
			|=> st.mode == bfs_pkg::M_FAULT && st.cause[bfs_pkg::CAUSE_LOWER];
	endproperty
	a_lower_sample: assert property (p_lower_sample) else $error("Lower fault missed.");

	property p_lower_only_edge;
		st.mode == bfs_pkg::M_RUN && !lo_fall && !csu_s && ok_in |=> st.mode == bfs_pkg::M_RUN;
	endproperty
	a_lower_only_edge: assert property (p_lower_only_edge)
		else $error("Fault off edge.");

	property p_sd_clears;
		sd_s && sup_s |=> !fault_latch && st.mode == bfs_pkg::M_SHUTDOWN;
	endproperty
	a_sd_clears: assert property (p_sd_clears) else $error("Shutdown kept fault.");

	property p_sd_release;
		st.mode == bfs_pkg::M_SHUTDOWN && !sd_s && sup_s |=> st.mode == bfs_pkg::M_IDLE;
	endproperty
	a_sd_release: assert property (p_sd_release)
		else $error("No restart after shutdown.");

	property p_uvlo_clears;
		!sup_s |=> !fault_latch && st.mode == bfs_pkg::M_IDLE;
	endproperty
	a_uvlo_clears: assert property (p_uvlo_clears) else $error("Lockout kept fault.");

	property p_preheat_end;
		st.mode == bfs_pkg::M_PREHEAT && capl_s && ok_in
			|=> st.mode == bfs_pkg::M_IGNITION && preheat_resistor_node_oe_n;
	endproperty
	a_preheat_end: assert property (p_preheat_end) else $error("Preheat did not end.");

	property p_run_entry;
		st.mode == bfs_pkg::M_IGNITION && caph_s && !csu_s && ok_in
			|=> !run_switch_oe_n && st.irq_stat[bfs_pkg::IRQ_RUN_ENTRY];
	endproperty
	a_run_entry: assert property (p_run_entry) else $error("Run not entered.");

	property p_stopped_low;
		!running |-> !low_side_drive && !high_side_drive;
	endproperty
	a_stopped_low: assert property (p_stopped_low) else $error("Drive while stopped.");

	property p_fault_holds;
		st.mode == bfs_pkg::M_FAULT && !sd_s && sup_s |=> st.mode == bfs_pkg::M_FAULT && fault_latch;
	endproperty
	a_fault_holds: assert property (p_fault_holds)
		else $error("Fault latch not held.");

	property p_irq_fault;
		st.irq_stat[bfs_pkg::IRQ_FAULT] && st.irq_mask[bfs_pkg::IRQ_FAULT] |-> irq;
	endproperty
	a_irq_fault: assert property (p_irq_fault)
		else $error("Fault interrupt not raised.");

	c_run: cover property (st.mode == bfs_pkg::M_IGNITION ##1 st.mode == bfs_pkg::M_RUN);
	c_fault: cover property ($rose(fault_latch));
	c_sd_restart: cover property (st.mode == bfs_pkg::M_SHUTDOWN ##1 st.mode == bfs_pkg::M_IDLE);
	c_bus_drop: cover property (running ##1 st.mode == bfs_pkg::M_IDLE && sup_s);

endmodule : bfs_sequencer
`default_nettype wire

// >>> sim/bfs_stage_model.sv
// Behavioural half-bridge stage with oscillator, preheat capacitor and current sense levels.
`timescale 1ns/100ps
`default_nettype none
module bfs_stage_model #(
	parameter int unsigned PH_LOW  = 160,
	parameter int unsigned PH_HIGH = 200
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic osc_enable,
	input  wire logic upper_fail,
	input  wire logic lower_fail,
	output logic      osc_low_cmd,
	output logic      osc_high_cmd,
	output logic      cs_upper_crossed,
	output logic      cs_lower_crossed,
	output logic      cap_low,
	output logic      cap_high
);
	int unsigned cap_cnt;
	logic [2:0]  phase;
	// The capacitor is discharged whenever oscillation stops, so a restart replays preheat.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_cnt <= 0;
			phase   <= 3'h0;
		end else if (!osc_enable) begin
			cap_cnt <= 0;
			phase   <= 3'h0;
		end else begin
			cap_cnt <= cap_cnt + 1;
			phase   <= phase + 3'h1;
		end
	end
	assign osc_low_cmd      = osc_enable && !phase[2];
	assign osc_high_cmd     = osc_enable && phase[2];
	assign cap_low          = cap_cnt >= PH_LOW;
	assign cap_high         = cap_cnt >= PH_HIGH;
	assign cs_upper_crossed = upper_fail;
	// A missing current pulse shows as a lower threshold that is never reached.
	assign cs_lower_crossed = !lower_fail;
endmodule : bfs_stage_model
`default_nettype wire

// >>> sim/ballast_fault_sequencer_tb_top.sv
// Self-checking testbench of the ballast fault sequencer.
`timescale 1ns/100ps
`default_nettype none
module ballast_fault_sequencer_tb_top;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, supply_ok, bus_ok, sd, up_f, lo_f;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic        osc_lo, osc_hi, cs_up, cs_lo, cap_lo, cap_hi, osc_en, lsd, hsd, mp, flt;
	logic        phr_out, phr_oe_n, run_out, run_oe_n, irq, dph;
	logic [63:0] exq[$];
	logic [63:0] note;
	int          fails = 0;
	int          checks = 0;
	bfs_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply_ok(supply_ok),
		.bus_voltage_sense(bus_ok), .lamp_sense_shutdown(sd), .cs_upper_crossed(cs_up),
		.cs_lower_crossed(cs_lo), .preheat_cap_low_thr(cap_lo), .preheat_cap_high_thr(cap_hi),
		.osc_low_cmd(osc_lo), .osc_high_cmd(osc_hi), .osc_enable(osc_en), .low_side_drive(lsd),
		.high_side_drive(hsd), .micropower(mp), .fault_latch(flt),
		.preheat_resistor_node_out(phr_out), .preheat_resistor_node_oe_n(phr_oe_n),
		.run_switch_out(run_out), .run_switch_oe_n(run_oe_n), .irq(irq));
	bfs_stage_model stage (.hclk(hclk), .hresetn(hresetn), .osc_enable(osc_en),
		.upper_fail(up_f), .lower_fail(lo_f), .osc_low_cmd(osc_lo), .osc_high_cmd(osc_hi),
		.cs_upper_crossed(cs_up), .cs_lower_crossed(cs_lo), .cap_low(cap_lo), .cap_high(cap_hi));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic give_verdict;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	task automatic cmp_rd(input logic [31:0] got, input logic [63:0] n);
		checks++;
		if ((got & n[63:32]) !== (n[31:0] & n[63:32])) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got & n[63:32], n[31:0] & n[63:32]);
		end
	endtask : cmp_rd
	task automatic cmp_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_pin
	// Read results are compared here, in the order the driver noted them.
	always @(posedge hclk) begin
		if (dph && hreadyout === 1'b1) begin
			note = exq.pop_front();
			if (note[63:32] != 32'h0) cmp_rd(hrdata, note);
		end
		dph <= hsel && htrans == bfs_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
	end
	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			give_verdict();
		end
	endtask : hwait
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] m, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {28'h0, a};
		htrans <= bfs_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) exq.push_back({m, d});
		hwait();
		q = hrdata;
	endtask : xfer
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		xfer(1'b0, a, e, m, q);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, 32'h0, q);
	endtask : wr
	// Polls the mode with a bound, then notes the expected mode and the status bits under mask m.
	task automatic wait_mode(input bfs_pkg::bfs_mode_t md, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] q;
		int          i;
		for (i = 0; i < 120; i++) begin
			xfer(1'b0, bfs_pkg::OFS_STATUS, 32'h0, 32'h0, q);
			if (q[5:0] === md) break;
		end
		if (i >= 120) begin
			fails++;
			give_verdict();
		end
		rd(bfs_pkg::OFS_STATUS, e | {26'h0, md}, m | 32'h3F);
	endtask : wait_mode
	initial begin
		{hsel, hwrite, supply_ok, bus_ok, sd, up_f, lo_f, hresetn} = 8'h0;
		haddr  = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		r = $urandom(32'h6372);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(bfs_pkg::OFS_CTRL, 32'h1, 32'h1);
		rd(bfs_pkg::OFS_IRQ_STAT, 32'h0, 32'hF);
		rd(bfs_pkg::OFS_IRQ_MASK, 32'h0, 32'hF);
		rd(bfs_pkg::OFS_STATUS, 32'h1, 32'h1FF);
		r = $urandom();
		wr(bfs_pkg::OFS_IRQ_MASK, r);
		rd(bfs_pkg::OFS_IRQ_MASK, r, 32'hF);
		wr(bfs_pkg::OFS_IRQ_MASK, 32'h0);
		supply_ok <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(bfs_pkg::OFS_STATUS, 32'h1, 32'h3F);
		cmp_pin(osc_en, 1'b0);
		bus_ok <= 1'b1;
		wait_mode(bfs_pkg::M_PREHEAT, 32'h0, 32'h0);
		cmp_pin(phr_oe_n, 1'b0);
		up_f <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(bfs_pkg::OFS_STATUS, 32'h2, 32'h3F);
		wait_mode(bfs_pkg::M_FAULT, 32'h300, 32'h300);
		cmp_pin(lsd | hsd, 1'b0);
		cmp_pin(mp, 1'b1);
		cmp_pin(irq, 1'b0);
		wr(bfs_pkg::OFS_IRQ_MASK, 32'h1);
		rd(bfs_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
		cmp_pin(irq, 1'b1);
		wr(bfs_pkg::OFS_IRQ_STAT, 32'hF);
		rd(bfs_pkg::OFS_IRQ_STAT, 32'h0, 32'h1);
		cmp_pin(irq, 1'b0);
		up_f <= 1'b0;
		sd   <= 1'b1;
		wait_mode(bfs_pkg::M_SHUTDOWN, 32'h0, 32'h100);
		cmp_pin(mp, 1'b1);
		cmp_pin(lsd | hsd | flt, 1'b0);
		sd <= 1'b0;
		wait_mode(bfs_pkg::M_PREHEAT, 32'h0, 32'h0);
		wait_mode(bfs_pkg::M_IGNITION, 32'h0, 32'h0);
		cmp_pin(phr_oe_n, 1'b1);
		cmp_pin(phr_out, 1'b0);
		wait_mode(bfs_pkg::M_RUN, 32'h0, 32'h0);
		cmp_pin(run_oe_n, 1'b0);
		cmp_pin(run_out, 1'b0);
		cmp_pin(hresp, 1'b0);
		rd(bfs_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
		// In steady run exactly one gate drive is on, since the stage commands are complementary.
		cmp_pin(lsd ^ hsd, 1'b1);
		bus_ok <= 1'b0;
		wait_mode(bfs_pkg::M_IDLE, 32'h0, 32'h0);
		cmp_pin(lsd | hsd | osc_en, 1'b0);
		rd(bfs_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
		bus_ok <= 1'b1;
		wait_mode(bfs_pkg::M_PREHEAT, 32'h0, 32'h0);
		lo_f <= 1'b1;
		wait_mode(bfs_pkg::M_IGNITION, 32'h0, 32'h0);
		wait_mode(bfs_pkg::M_FAULT, 32'h500, 32'h700);
		supply_ok <= 1'b0;
		wait_mode(bfs_pkg::M_IDLE, 32'h0, 32'h100);
		cmp_pin(flt, 1'b0);
		give_verdict();
	end
endmodule : ballast_fault_sequencer_tb_top
`default_nettype wire
